// *** core/msr_defines.svh ***
`ifndef MSR_DEFINES_SVH
`define MSR_DEFINES_SVH

// Terminal function codes
`define MSR_FN_DIR      8'h00
`define MSR_FN_REF1     8'h03
`define MSR_FN_REF2     8'h04
`define MSR_FN_REF3     8'h05
`define MSR_FN_JOG      8'h06
`define MSR_FN_BB       8'h08
`define MSR_FN_ANA      8'h0C
`define MSR_FN_SS_MAX   8'h61
`define MSR_FN_SS_SET   8'h62

// Operator status codes
`define MSR_ST_DRIVE    4'h0
`define MSR_ST_INIT_2W  4'hE
`define MSR_ST_INIT_3W  4'hF

// Reference modes
`define MSR_MODE_1      3'h1
`define MSR_MODE_2      3'h2
`define MSR_MODE_3      3'h3
`define MSR_MODE_4      3'h4
`define MSR_MODE_5      3'h5

// Configuration select codes
`define MSR_CFG_TERM5   3'h0
`define MSR_CFG_TERM6   3'h1
`define MSR_CFG_TERM7   3'h2
`define MSR_CFG_TERM8   3'h3
`define MSR_CFG_DEACT   3'h4
`define MSR_CFG_DECEL   3'h5
`define MSR_CFG_OPMODE  3'h6
`define MSR_CFG_ANAFN   3'h7

// Factory values
`define MSR_DEACT_DEF   8'h96
`define MSR_DECEL_DEF   8'h14
`define MSR_DECEL_OFF   8'h00
`define MSR_OPMODE_DEF  4'h0
`define MSR_ANAFN_MAN   8'h00
`define MSR_OPM_LOCAL   0

// Terminal positions in the selection word
`define MSR_T5          0
`define MSR_T6          1
`define MSR_T7          2
`define MSR_T8          3

// Timing
`define MSR_CLK_MHZ     125
`define MSR_BLOCK_MS    500
`define MSR_DECEL_STEP_MS 100

`endif

// *** core/msr_pkg.sv ***
package msr_pkg;

	typedef enum logic [1:0] {
		MSR_SRC_PRESET,
		MSR_SRC_MANUAL,
		MSR_SRC_AUTO,
		MSR_SRC_JOG
	} msr_src_e;

	typedef logic [3:0][7:0] msr_funcs_t;

	typedef struct packed {
		logic [15:0] jog_speed_preset;
		logic [15:0] preset_speed_eight;
		logic [15:0] preset_speed_seven;
		logic [15:0] preset_speed_six;
		logic [15:0] preset_speed_five;
		logic [15:0] preset_speed_four;
		logic [15:0] preset_speed_three;
		logic [15:0] preset_speed_two;
		logic [15:0] preset_speed_one;
	} msr_presets_s;

	typedef struct packed {
		logic [15:0] auto_ref;
		logic [15:0] manual_ref;
		logic [15:0] max_freq;
	} msr_refs_s;

endpackage

// *** core/msr_select.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "msr_defines.svh"

module msr_select #(
	parameter int BLOCK_CYCLES = `MSR_BLOCK_MS * 1000 * `MSR_CLK_MHZ
) (
	input  wire logic                 sys_clk,
	input  wire logic                 rst,
	input  wire logic [3:0]           term_in,
	input  wire logic [2:0]           ref_mode,
	input  wire msr_pkg::msr_presets_s presets,
	input  wire msr_pkg::msr_refs_s    refs,
	input  wire logic [7:0]           output_current,
	input  wire logic                 cfg_wr,
	input  wire logic [2:0]           cfg_sel,
	input  wire logic [7:0]           cfg_wdata,
	input  wire logic                 status_wr,
	input  wire logic [3:0]           status_wdata,
	output logic [15:0]               freq_ref,
	output logic [3:0]                ref_index,
	output msr_pkg::msr_src_e          ref_source,
	output logic                      direction_select,
	output logic                      drive_enable,
	output logic [3:0]                operator_status_const,
	output msr_pkg::msr_funcs_t        input_funcs,
	output logic [3:0]                operation_mode_select,
	output logic [7:0]                analog_input_function,
	output logic [7:0]                search_deactivate_current,
	output logic [7:0]                search_decel_time,
	output logic                      ss_baseblock,
	output logic                      ss_active,
	output logic [15:0]               ss_start_freq,
	output logic                      ss_done
);

	typedef enum logic [1:0] {
		MSR_SS_IDLE,
		MSR_SS_BLOCK,
		MSR_SS_SEARCH
	} msr_ss_e;

	logic [3:0]          term_meta;
	logic [3:0]          term_sync;
	logic                init_now;
	logic                init_3w;
	logic [3:0]          sel_bits;
	logic                jog_req;
	logic                ana_req;
	logic                dir_req;
	logic                ss_req;
	logic                ss_from_max;
	logic                ss_req_d;
	logic [3:0]          next_index;
	msr_pkg::msr_src_e    next_source;
	logic [15:0]         next_freq;
	msr_ss_e              ss_state;
	logic [25:0]         ss_cnt;
	logic                ss_go;
	logic                ss_blk_done;
	logic                ss_srch_done;
	logic                ss_max_sel;

	// Contacts bounce and change asynchronously to the clock
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			term_meta <= 4'h0;
			term_sync <= 4'h0;
		end else begin
			term_meta <= term_in;
			term_sync <= term_meta;
		end
	end

	// Operator status: a written init code acts on the following edge
	assign init_now = (operator_status_const == `MSR_ST_INIT_2W) ||
	                  (operator_status_const == `MSR_ST_INIT_3W);
	assign init_3w  = (operator_status_const == `MSR_ST_INIT_3W);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			operator_status_const <= `MSR_ST_DRIVE;
		end else if (init_now) begin
			operator_status_const <= `MSR_ST_DRIVE;
		end else if (status_wr) begin
			operator_status_const <= status_wdata;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			drive_enable <= 1'b0;
		end else begin
			drive_enable <= (operator_status_const == `MSR_ST_DRIVE) &&
			                !status_wr;
		end
	end

	// Constants; initialization overrides a concurrent write.
	// Capacity and V/f live elsewhere and are never touched here.
	always_ff @(posedge sys_clk) begin
		if (rst || (init_now && !init_3w)) begin
			input_funcs[`MSR_T5] <= `MSR_FN_REF1;
			input_funcs[`MSR_T6] <= `MSR_FN_REF2;
			input_funcs[`MSR_T7] <= `MSR_FN_JOG;
			input_funcs[`MSR_T8] <= `MSR_FN_BB;
		end else if (init_now) begin
			input_funcs[`MSR_T5] <= `MSR_FN_DIR;
			input_funcs[`MSR_T6] <= `MSR_FN_REF1;
			input_funcs[`MSR_T7] <= `MSR_FN_REF2;
			input_funcs[`MSR_T8] <= `MSR_FN_JOG;
		end else if (cfg_wr) begin
			case (cfg_sel)
				`MSR_CFG_TERM5: input_funcs[`MSR_T5] <= cfg_wdata;
				`MSR_CFG_TERM6: input_funcs[`MSR_T6] <= cfg_wdata;
				`MSR_CFG_TERM7: input_funcs[`MSR_T7] <= cfg_wdata;
				`MSR_CFG_TERM8: input_funcs[`MSR_T8] <= cfg_wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst || init_now) begin
			search_deactivate_current <= `MSR_DEACT_DEF;
			search_decel_time         <= `MSR_DECEL_DEF;
			operation_mode_select     <= `MSR_OPMODE_DEF;
			analog_input_function     <= `MSR_ANAFN_MAN;
		end else if (cfg_wr) begin
			case (cfg_sel)
				`MSR_CFG_DEACT:  search_deactivate_current <= cfg_wdata;
				`MSR_CFG_DECEL:  search_decel_time <= cfg_wdata;
				`MSR_CFG_OPMODE: operation_mode_select <= cfg_wdata[3:0];
				`MSR_CFG_ANAFN:  analog_input_function <= cfg_wdata;
				default: ;
			endcase
		end
	end

	// Terminal decode: each function code drives one bit; both search codes share ss_req and MSR_FN_SS_MAX also sets ss_from_max
	always_comb begin
		sel_bits    = 4'h0;
		jog_req     = 1'b0;
		ana_req     = 1'b0;
		dir_req     = 1'b0;
		ss_req      = 1'b0;
		ss_from_max = 1'b0;
		for (int i = 0; i < 4; i++) begin
			// Unassigned or foreign functions leave their bit at zero
			case (input_funcs[i])
				`MSR_FN_REF1: sel_bits[0] = term_sync[i] | sel_bits[0];
				`MSR_FN_REF2: sel_bits[1] = term_sync[i] | sel_bits[1];
				`MSR_FN_REF3: sel_bits[2] = term_sync[i] | sel_bits[2];
				`MSR_FN_JOG:  jog_req = term_sync[i] | jog_req;
				`MSR_FN_ANA:  ana_req = term_sync[i] | ana_req;
				`MSR_FN_DIR:  dir_req = term_sync[i] | dir_req;
				`MSR_FN_SS_MAX: begin
					ss_req      = term_sync[i] | ss_req;
					ss_from_max = 1'b1;
				end
				`MSR_FN_SS_SET: ss_req = term_sync[i] | ss_req;
				default: ;
			endcase
		end
		sel_bits[3] = jog_req | ana_req;
	end

	// Reference choice; a closed analog or jog input overrides the lower bits
	always_comb begin
		next_index  = sel_bits;
		next_source = msr_pkg::MSR_SRC_PRESET;
		next_freq   = presets.preset_speed_one;
		if (ana_req) begin
			next_source = msr_pkg::MSR_SRC_MANUAL;
			next_freq   = refs.manual_ref;
		end else if (jog_req) begin
			next_source = msr_pkg::MSR_SRC_JOG;
			next_freq   = presets.jog_speed_preset;
		end else begin
			case (sel_bits[2:0])
				3'h0: begin
					// Mode 4 keeps preset one on code zero even under remote operation
					if (!operation_mode_select[`MSR_OPM_LOCAL] &&
					    ref_mode != `MSR_MODE_4) begin
						next_source = msr_pkg::MSR_SRC_AUTO;
						next_freq   = refs.auto_ref;
					end else begin
						next_freq = presets.preset_speed_one;
					end
				end
				3'h1: begin
					if (ref_mode == `MSR_MODE_3 ||
					    analog_input_function == `MSR_ANAFN_MAN) begin
						next_source = msr_pkg::MSR_SRC_MANUAL;
						next_freq   = refs.manual_ref;
					end else begin
						next_freq = presets.preset_speed_two;
					end
				end
				3'h2: next_freq = presets.preset_speed_three;
				3'h3: next_freq = presets.preset_speed_four;
				3'h4: next_freq = presets.preset_speed_five;
				3'h5: next_freq = presets.preset_speed_six;
				3'h6: next_freq = presets.preset_speed_seven;
				3'h7: next_freq = presets.preset_speed_eight;
				default: next_freq = presets.preset_speed_one;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ref_index        <= 4'h0;
			ref_source       <= msr_pkg::MSR_SRC_PRESET;
			freq_ref         <= 16'h0000;
			direction_select <= 1'b0;
		end else begin
			ref_index        <= next_index;
			ref_source       <= next_source;
			freq_ref         <= next_freq;
			direction_select <= dir_req;
		end
	end

	// Speed search sequencer; only a fresh closure starts it
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ss_req_d <= 1'b0;
		end else begin
			ss_req_d <= ss_req;
		end
	end

	// Step conditions shared by the per-concern registers below
	assign ss_go        = ss_req && !ss_req_d &&
	                      (search_decel_time != `MSR_DECEL_OFF) &&
	                      (ss_state == MSR_SS_IDLE);
	assign ss_blk_done  = (ss_state == MSR_SS_BLOCK) &&
	                      (ss_cnt == 26'(BLOCK_CYCLES - 1));
	assign ss_srch_done = (ss_state == MSR_SS_SEARCH) &&
	                      (output_current <= search_deactivate_current);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ss_state <= MSR_SS_IDLE;
		end else begin
			case (ss_state)
				MSR_SS_IDLE: begin
					if (ss_go) begin
						ss_state <= MSR_SS_BLOCK;
					end
				end
				MSR_SS_BLOCK: begin
					if (ss_blk_done) begin
						ss_state <= MSR_SS_SEARCH;
					end
				end
				MSR_SS_SEARCH: begin
					if (ss_srch_done) begin
						ss_state <= MSR_SS_IDLE;
					end
				end
				default: begin
					ss_state <= MSR_SS_IDLE;
				end
			endcase
		end
	end

	// Counter is wide enough for the default block time only
	always_ff @(posedge sys_clk) begin
		if (rst || ss_state != MSR_SS_BLOCK) begin
			ss_cnt <= 26'h0000000;
		end else begin
			ss_cnt <= ss_cnt + 26'h0000001;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst || ss_blk_done) begin
			ss_baseblock <= 1'b0;
		end else if (ss_go) begin
			ss_baseblock <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst || ss_srch_done) begin
			ss_active <= 1'b0;
		end else if (ss_blk_done) begin
			ss_active <= 1'b1;
		end
	end

	// Function codes may be rewritten mid-block; at the start, any input assigned MSR_FN_SS_MAX, closed or not, selects max
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ss_max_sel <= 1'b0;
		end else if (ss_go) begin
			ss_max_sel <= ss_from_max;
		end
	end

	// Set-frequency search takes the reference now in effect
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ss_start_freq <= 16'h0000;
		end else if (ss_blk_done) begin
			ss_start_freq <= ss_max_sel ? refs.max_freq
			                            : freq_ref;
		end
	end

	// One-cycle pulse lets the ramp resume toward the set frequency
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ss_done <= 1'b0;
		end else begin
			ss_done <= ss_srch_done;
		end
	end

endmodule

`default_nettype wire

// *** tb/msr_contacts.sv ***
`timescale 1ns/10ps
`default_nettype none
module msr_contacts #(
	parameter int SETTLE_NS = 3
) (
	input  wire logic [3:0] closed,
	output logic [3:0]      term_in
);
	initial term_in = 4'h0;
	// Bit 0 is terminal 5; contacts land off the clock grid so the synchroniser is exercised
	always @(closed) begin
		term_in <= #(SETTLE_NS) closed;
	end
endmodule
`default_nettype wire

// *** tb/msr_select_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module msr_select_properties #(
	parameter int BLOCK_CYCLES = 8
) (
	input wire logic               sys_clk,
	input wire logic               rst,
	input wire logic               status_wr,
	input wire logic [3:0]         status_wdata,
	input wire logic [7:0]         output_current,
	input wire logic [3:0]         ref_index,
	input wire logic [15:0]        freq_ref,
	input wire msr_pkg::msr_presets_s presets,
	input wire msr_pkg::msr_src_e  ref_source,
	input wire logic               drive_enable,
	input wire logic [3:0]         operator_status_const,
	input wire msr_pkg::msr_funcs_t input_funcs,
	input wire logic [7:0]         search_deactivate_current,
	input wire logic [7:0]         search_decel_time,
	input wire logic               ss_baseblock,
	input wire logic               ss_active,
	input wire logic               ss_done
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic [31:0] blk_cnt;
	// A counter, since a repetition cannot span the block length
	always_ff @(posedge sys_clk) begin
		if (rst || !ss_baseblock) begin
			blk_cnt <= '0;
		end else begin
			blk_cnt <= blk_cnt + 1;
		end
	end
	sequence s_block_end;
		$fell(ss_baseblock) ##0 ss_active;
	endsequence
	sequence s_search_end;
		!ss_active && ss_done ##1 !ss_done;
	endsequence
	property p_block_len;
		$fell(ss_baseblock) |-> s_block_end ##0 (blk_cnt == BLOCK_CYCLES);
	endproperty
	property p_search_end;
		ss_active && output_current <= search_deactivate_current |=> s_search_end;
	endproperty
	property p_decel_off;
		search_decel_time == 8'h00 && !ss_baseblock && !ss_active |=> !ss_baseblock;
	endproperty
	property p_status_load;
		status_wr |=> operator_status_const == $past(status_wdata);
	endproperty
	property p_init_clear;
		operator_status_const inside {4'hE, 4'hF} |=> operator_status_const == 4'h0;
	endproperty
	property p_init_2w;
		operator_status_const == 4'hE |=> input_funcs == {8'h08, 8'h06, 8'h04, 8'h03};
	endproperty
	property p_init_3w;
		operator_status_const == 4'hF |=> input_funcs == {8'h06, 8'h04, 8'h03, 8'h00};
	endproperty
	property p_drive;
		drive_enable |-> $past(operator_status_const) == 4'h0 && !$past(status_wr);
	endproperty
	property p_jog_index;
		ref_source == msr_pkg::MSR_SRC_JOG |->
			ref_index[3] && freq_ref == $past(presets.jog_speed_preset);
	endproperty
	a_block_len: assert property (p_block_len) else $error("block length wrong");
	a_search_end: assert property (p_search_end) else $error("search end wrong");
	a_decel_off: assert property (p_decel_off) else $error("search not disabled");
	a_status_load: assert property (p_status_load) else $error("status not loaded");
	a_init_clear: assert property (p_init_clear) else $error("status not cleared");
	a_init_2w: assert property (p_init_2w) else $error("two-wire set wrong");
	a_init_3w: assert property (p_init_3w) else $error("three-wire set wrong");
	a_drive: assert property (p_drive) else $error("drive enabled early");
	a_jog_index: assert property (p_jog_index) else $error("jog index bit low");
endmodule
bind msr_select msr_select_properties #(.BLOCK_CYCLES(BLOCK_CYCLES)) u_props (
	.sys_clk, .rst, .status_wr, .status_wdata, .output_current, .ref_index, .ref_source,
	.freq_ref, .presets,
	.drive_enable, .operator_status_const, .input_funcs, .search_deactivate_current,
	.search_decel_time, .ss_baseblock, .ss_active, .ss_done);
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic                  sys_clk, rst, cfg_wr, status_wr, direction_select, drive_enable;
	logic                  ss_baseblock, ss_active, ss_done;
	logic [3:0]            closed, term_in, ref_index, status_wdata, operator_status_const;
	logic [3:0]            operation_mode_select;
	logic [2:0]            ref_mode, cfg_sel;
	logic [7:0]            output_current, cfg_wdata, analog_input_function;
	logic [7:0]            search_deactivate_current, search_decel_time;
	logic [15:0]           freq_ref, ss_start_freq;
	msr_pkg::msr_presets_s presets;
	msr_pkg::msr_refs_s    refs;
	msr_pkg::msr_src_e     ref_source;
	msr_pkg::msr_funcs_t   input_funcs;
	int                    miscompares, comparisons, i, n;
	msr_contacts u_contacts (.closed, .term_in);
	msr_select #(.BLOCK_CYCLES(8)) dut (.sys_clk, .rst, .term_in, .ref_mode, .presets, .refs,
		.output_current, .cfg_wr, .cfg_sel, .cfg_wdata, .status_wr, .status_wdata, .freq_ref,
		.ref_index, .ref_source, .direction_select, .drive_enable, .operator_status_const,
		.input_funcs, .operation_mode_select, .analog_input_function,
		.search_deactivate_current, .search_decel_time, .ss_baseblock, .ss_active,
		.ss_start_freq, .ss_done);
	initial begin
		sys_clk = 0;
		forever #4 sys_clk = ~sys_clk;
	end
	task automatic tally_and_finish;
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cfg(input logic [2:0] s, input logic [7:0] d);
		@(negedge sys_clk);
		cfg_wr = 1;
		cfg_sel = s;
		cfg_wdata = d;
		@(negedge sys_clk);
		cfg_wr = 0;
	endtask
	task automatic stat(input logic [3:0] d);
		@(negedge sys_clk);
		status_wr = 1;
		status_wdata = d;
		@(negedge sys_clk);
		status_wr = 0;
		chk(drive_enable, 0);
		repeat (2) @(negedge sys_clk);
		chk(drive_enable, 1);
	endtask
	// Fixed wait covers the contact settle plus the three-edge answer
	task automatic pick(input logic [3:0] c, input logic [15:0] f, input logic [1:0] s);
		@(negedge sys_clk);
		closed = c;
		repeat (5) @(negedge sys_clk);
		chk(freq_ref, f);
		chk(ref_source, s);
	endtask
	task automatic ss_run(input logic [7:0] fn, input logic [15:0] f);
		closed = 0;
		output_current = 8'hC8;
		cfg(3, fn);
		repeat (4) @(negedge sys_clk);
		closed = 4'h8;
		n = 0;
		while (ss_baseblock !== 1'b1 && n < 20) begin
			n++;
			@(negedge sys_clk);
		end
		n = 0;
		while (ss_baseblock === 1'b1 && n < 50) begin
			n++;
			@(negedge sys_clk);
		end
		chk(n, 8);
		chk(ss_active, 1);
		chk(ss_start_freq, f);
		output_current = 8'h64;
		n = 0;
		while (ss_done !== 1'b1 && n < 5) begin
			n++;
			@(negedge sys_clk);
		end
		chk(ss_done, 1);
	endtask
	initial begin
		#100000;
		miscompares++;
		tally_and_finish;
	end
	initial begin
		{rst, cfg_wr, status_wr, cfg_sel, cfg_wdata, status_wdata} = '0;
		{closed, output_current} = '0;
		ref_mode = 3'h1;
		for (i = 0; i < 9; i++) presets[i*16 +: 16] = 16'h1101 + 16'(i);
		refs = {16'h2AAA, 16'h3BBB, 16'h4CCC};
		rst = 1;
		repeat (2) @(negedge sys_clk);
		rst = 0;
		repeat (2) @(negedge sys_clk);
		chk(input_funcs, 32'h08060403);
		chk(search_deactivate_current, 8'h96);
		chk(search_decel_time, 8'h14);
		chk(operation_mode_select, 4'h0);
		chk(analog_input_function, 8'h00);
		chk(drive_enable, 1);
		$display("test reset done");
		cfg(2, 8'h05);
		cfg(3, 8'h06);
		cfg(6, 8'h01);
		cfg(7, 8'h01);
		for (i = 0; i < 8; i++) pick(4'(i), 16'h1101 + 16'(i), msr_pkg::MSR_SRC_PRESET);
		pick(4'hD, 16'h1109, msr_pkg::MSR_SRC_JOG);
		chk(ref_index, 4'hD);
		cfg(6, 8'h00);
		pick(4'h0, 16'h2AAA, msr_pkg::MSR_SRC_AUTO);
		ref_mode = 3'h3;
		cfg(6, 8'h01);
		pick(4'h1, 16'h3BBB, msr_pkg::MSR_SRC_MANUAL);
		pick(4'h0, 16'h1101, msr_pkg::MSR_SRC_PRESET);
		ref_mode = 3'h4;
		cfg(3, 8'h0C);
		pick(4'hB, 16'h3BBB, msr_pkg::MSR_SRC_MANUAL);
		pick(4'h7, 16'h1108, msr_pkg::MSR_SRC_PRESET);
		cfg(6, 8'h00);
		pick(4'h0, 16'h1101, msr_pkg::MSR_SRC_PRESET);
		$display("test modes done");
		ref_mode = 3'h1;
		stat(4'hF);
		chk(input_funcs, 32'h06040300);
		chk(operator_status_const, 4'h0);
		chk(analog_input_function, 8'h00);
		pick(4'h5, 16'h1103, msr_pkg::MSR_SRC_PRESET);
		chk(direction_select, 1);
		pick(4'h3, 16'h3BBB, msr_pkg::MSR_SRC_MANUAL);
		cfg(5, 8'h05);
		stat(4'hE);
		chk(search_decel_time, 8'h14);
		chk(input_funcs, 32'h08060403);
		pick(4'hB, 16'h1104, msr_pkg::MSR_SRC_PRESET);
		chk(ref_index, 4'h3);
		$display("test init done");
		ss_run(8'h61, 16'h4CCC);
		ss_run(8'h62, 16'h2AAA);
		cfg(5, 8'h00);
		closed = 0;
		repeat (4) @(negedge sys_clk);
		closed = 4'h8;
		output_current = 8'hC8;
		repeat (20) @(negedge sys_clk);
		chk(ss_baseblock, 0);
		$display("test search done");
		tally_and_finish;
	end
endmodule
`default_nettype wire
